// ==== flash_lock_defs.svh ====
/*
 Constants of the block lock, reset and unique id command logic.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef FLASH_LOCK_DEFS_SVH
`define FLASH_LOCK_DEFS_SVH

`define OP_SINGLE_LOCK   8'h36
`define OP_SINGLE_UNLOCK 8'h39
`define OP_LOCK_QUERY    8'h3C
`define OP_ALL_LOCK      8'h7E
`define OP_ALL_UNLOCK    8'h98
`define OP_LATCH_SET     8'h06
`define OP_LATCH_CLR     8'h04
`define OP_RESET_ARM     8'h66
`define OP_RESET_FIRE    8'h99
`define OP_UID_DEFAULT   8'h4B

`define ADDR_W        22
`define UNIT_W        7
`define LOCK_UNITS    94
`define LOCK_RESET    1'b1

`define BITS_OPCODE   8'h08
`define BITS_ADDR_CMD 8'h20
`define BITS_UID_DATA 8'h28
`define UID_W         128

`define RESET_PULSE_NS 1000
`define CLK_MHZ        200
`define RESET_PULSE_CYC ((`RESET_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== flash_lock_pkg.sv ====
/*
 Types and the address to lock unit decode.
 Assumes flash_lock_defs.svh is on the include path.
*/
`include "flash_lock_defs.svh"

package flash_lock_pkg;

  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`UNIT_W-1:0] unit_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
  } cmd_t;

  typedef struct packed {
    logic  valid;
    addr_t addr;
  } pe_req_t;

  typedef enum logic [1:0] {
    ARM_IDLE = 2'b01,
    ARM_SET  = 2'b10
  } arm_state_t;

  // bottom/top 64KB blocks split into 16 sectors each, others whole
  function automatic unit_t unit_of(input addr_t a);
    logic [5:0] blk;
    blk = a[21:16];
    if (blk == 6'h00)
      return unit_t'(a[15:12]);
    else if (blk == 6'h3F)
      return unit_t'({3'h1, a[15:12]});
    else
      return unit_t'(7'h1F + {1'b0, blk});
  endfunction

endpackage

// ==== lock_bit_store.sv ====
/*
 Volatile per-unit lock bits: writes on the core clock, one read port
 registered on the core clock and one registered on the link clock.
 Assumes the link side reads only while no write can occur.
*/
`timescale 1ns/1ps
`include "flash_lock_defs.svh"

module lock_bit_store #(
  parameter int UNITS = `LOCK_UNITS
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 set_all_i,
  input  wire logic                 clr_all_i,
  input  wire logic                 wr_en_i,
  input  wire flash_lock_pkg::unit_t wr_idx_i,
  input  wire logic                 wr_val_i,
  input  wire flash_lock_pkg::unit_t chk_idx_i,
  output logic                      chk_o,
  input  wire logic                 rd_clk_i,
  input  wire logic                 rd_en_i,
  input  wire flash_lock_pkg::unit_t rd_idx_i,
  output logic                      rd_o
);

  logic [UNITS-1:0] bits_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bits_r <= {UNITS{`LOCK_RESET}};
    end else if (set_all_i) begin
      bits_r <= {UNITS{1'b1}};
    end else if (clr_all_i) begin
      bits_r <= '0;
    end else if (wr_en_i) begin
      bits_r[wr_idx_i] <= wr_val_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chk_o <= `LOCK_RESET;
    end else begin
      chk_o <= bits_r[chk_idx_i];
    end
  end

  // quasi-static: bits only change at select rise or in pin reset, never mid-frame
  always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_o <= `LOCK_RESET;
    end else if (rd_en_i) begin
      rd_o <= bits_r[rd_idx_i];
    end
  end

endmodule

// ==== flash_lock_ctrl.sv ====
/*
 Block lock, software/pin reset and unique id command logic of a
 serial flash. Link logic runs on the serial clock (mode 0: sample on
 rise, drive on fall); commands execute on the core clock at select rise.
 Assumes the serial clock stands still while select is high.
*/
`timescale 1ns/1ps
`include "flash_lock_defs.svh"

module flash_lock_ctrl #(
  parameter logic [7:0]        UID_OP      = `OP_UID_DEFAULT,
  // arbitrary value, each part would carry its own
  parameter logic [`UID_W-1:0] UNIQUE_ID   =
    128'h0123456789ABCDEF_FEDCBA9876543210,
  parameter int                PULSE_CYC   = `RESET_PULSE_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    sck_i,
  input  wire logic                    cs_b_i,
  input  wire logic                    reset_pin_b_i,
  input  wire logic [3:0]              io_i,
  output logic      [3:0]              io_o,
  output logic      [3:0]              io_oe_b_o,
  input  wire logic                    quad_command_mode_i,
  input  wire logic                    lock_scheme_select_i,
  input  wire logic                    range_protect_i,
  input  wire flash_lock_pkg::pe_req_t pe_req_i,
  output logic                         pe_go_o,
  output logic                         pe_refuse_o,
  output logic                         pe_abort_o,
  output logic                         write_latch_flag_o,
  output logic                         soft_reset_o
);

  // link side

  logic                  frame_clr;
  logic                  in_frame_r;
  logic                  quad_s1_r;
  logic                  quad_r;
  logic [7:0]            bcnt_r;
  logic [7:0]            bits_nxt;
  logic [8:0]            bits_sum;
  logic [7:0]            bpc;
  logic [31:0]           sh_r;
  logic [31:0]           sh_nxt;
  flash_lock_pkg::cmd_t  cmd_r;
  logic                  frame_tog_r;
  logic                  lk_rd;
  logic                  rd_en;
  flash_lock_pkg::unit_t rd_idx;
  logic [6:0]            ob_r;
  logic                  data_phase;
  logic [`UID_W-1:0]     out_word;

  // select high or reset pin low ends the frame without a clock edge
  assign frame_clr = cs_b_i | ~reset_pin_b_i | ~rst_b_i;

  always_ff @(posedge sck_i or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
    end
  end

  // mode level changes only between frames
  always_ff @(posedge sck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quad_s1_r <= 1'b0;
      quad_r    <= 1'b0;
    end else begin
      quad_s1_r <= quad_command_mode_i;
      quad_r    <= quad_s1_r;
    end
  end

  always_comb begin
    bpc      = quad_r ? 8'h04 : 8'h01;
    bits_sum = {1'b0, bcnt_r} + {1'b0, bpc};
    if (!in_frame_r)
      bits_nxt = bpc;
    else if (bits_sum[8])
      bits_nxt = 8'hFF;
    else
      bits_nxt = bits_sum[7:0];
    // upper lanes are ignored outside quad mode
    sh_nxt = quad_r ? {sh_r[27:0], io_i} : {sh_r[30:0], io_i[0]};
  end

  // count and command words stay put after select rises for the core
  always_ff @(posedge sck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bcnt_r      <= 8'h00;
      sh_r        <= 32'h0000_0000;
      cmd_r       <= '0;
      frame_tog_r <= 1'b0;
    end else begin
      bcnt_r <= bits_nxt;
      sh_r   <= sh_nxt;
      if (!in_frame_r)
        frame_tog_r <= ~frame_tog_r;
      if (bits_nxt == `BITS_OPCODE)
        cmd_r.op <= sh_nxt[7:0];
      if (bits_nxt == `BITS_ADDR_CMD)
        cmd_r.addr <= sh_nxt[23:0];
    end
  end

  assign rd_en = (bits_nxt == `BITS_ADDR_CMD) &&
                 (cmd_r.op == `OP_LOCK_QUERY);
  assign rd_idx = flash_lock_pkg::unit_of(sh_nxt[`ADDR_W-1:0]);

  always_comb begin
    data_phase = 1'b0;
    out_word   = UNIQUE_ID;
    if (cmd_r.op == `OP_LOCK_QUERY) begin
      data_phase = bcnt_r >= `BITS_ADDR_CMD;
      out_word   = {16{7'h00, lk_rd}};
    end else if (cmd_r.op == UID_OP) begin
      data_phase = bcnt_r >= `BITS_UID_DATA;
    end
  end

  always_ff @(negedge sck_i or posedge frame_clr) begin
    if (frame_clr) begin
      io_o      <= 4'h0;
      io_oe_b_o <= 4'hF;
      ob_r      <= 7'h00;
    end else if (data_phase && in_frame_r) begin
      if (quad_r) begin
        io_o      <= out_word[7'd127 - ob_r -: 4];
        io_oe_b_o <= 4'h0;
        ob_r      <= ob_r + 7'h04;
      end else begin
        io_o      <= {2'b00, out_word[7'd127 - ob_r], 1'b0};
        io_oe_b_o <= 4'hD;
        ob_r      <= ob_r + 7'h01;
      end
    end
  end

  // core side

  logic                       cs_s1_r;
  logic                       cs_s2_r;
  logic                       cs_d_r;
  logic                       tog_s1_r;
  logic                       tog_s2_r;
  logic                       tog_seen_r;
  logic                       pin_s1_r;
  logic                       pin_s2_r;
  logic [15:0]                pcnt_r;
  logic                       pin_rst_r;
  logic                       latch_r;
  flash_lock_pkg::arm_state_t arm_r;
  logic                       exec;
  logic                       len8;
  logic                       len32;
  logic                       do_lock;
  logic                       do_unlock;
  logic                       do_all_lock;
  logic                       do_all_unlock;
  logic                       fire;
  logic                       any_reset;
  logic                       pe_pend_r;
  logic                       chk_bit;
  logic                       locked;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      cs_d_r   <= 1'b1;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      cs_s1_r  <= cs_b_i;
      cs_s2_r  <= cs_s1_r;
      cs_d_r   <= cs_s2_r;
      tog_s1_r <= frame_tog_r;
      tog_s2_r <= tog_s1_r;
      pin_s1_r <= reset_pin_b_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // a select pulse with no clock leaves the toggle alone: nothing runs
  assign exec = cs_s2_r && !cs_d_r && (tog_s2_r != tog_seen_r) &&
                pin_s2_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tog_seen_r <= 1'b0;
    end else if (cs_s2_r && !cs_d_r) begin
      tog_seen_r <= tog_s2_r;
    end
  end

  // pin reset counts only once the low pulse has lasted long enough
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pcnt_r    <= 16'h0000;
      pin_rst_r <= 1'b0;
    end else if (pin_s2_r) begin
      pcnt_r    <= 16'h0000;
      pin_rst_r <= 1'b0;
    end else if (pcnt_r < 16'(PULSE_CYC - 1)) begin
      pcnt_r <= pcnt_r + 16'h0001;
    end else begin
      pin_rst_r <= 1'b1;
    end
  end

  // lock-type commands need an exact byte-aligned length
  assign len8  = bcnt_r == `BITS_OPCODE;
  assign len32 = bcnt_r == `BITS_ADDR_CMD;

  assign do_lock = exec && latch_r && len32 &&
                   (cmd_r.op == `OP_SINGLE_LOCK);
  assign do_unlock = exec && latch_r && len32 &&
                     (cmd_r.op == `OP_SINGLE_UNLOCK);
  assign do_all_lock = exec && latch_r && len8 &&
                       (cmd_r.op == `OP_ALL_LOCK);
  assign do_all_unlock = exec && latch_r && len8 &&
                         (cmd_r.op == `OP_ALL_UNLOCK);

  assign fire = exec && len8 && (cmd_r.op == `OP_RESET_FIRE) &&
                (arm_r == flash_lock_pkg::ARM_SET);
  assign any_reset = fire || pin_rst_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arm_r <= flash_lock_pkg::ARM_IDLE;
    end else if (any_reset) begin
      arm_r <= flash_lock_pkg::ARM_IDLE;
    end else if (exec) begin
      unique case (arm_r)
        flash_lock_pkg::ARM_IDLE: begin
          if (len8 && cmd_r.op == `OP_RESET_ARM)
            arm_r <= flash_lock_pkg::ARM_SET;
        end
        flash_lock_pkg::ARM_SET: begin
          arm_r <= flash_lock_pkg::ARM_IDLE;
        end
        default: begin
          arm_r <= flash_lock_pkg::ARM_IDLE;
        end
      endcase
    end
  end

  // lock commands use up the latch, as program and erase do
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latch_r <= 1'b0;
    end else if (any_reset) begin
      latch_r <= 1'b0;
    end else if (do_lock || do_unlock || do_all_lock || do_all_unlock) begin
      latch_r <= 1'b0;
    end else if (exec && len8 && cmd_r.op == `OP_LATCH_SET) begin
      latch_r <= 1'b1;
    end else if (exec && len8 && cmd_r.op == `OP_LATCH_CLR) begin
      latch_r <= 1'b0;
    end
  end

  lock_bit_store #(
    .UNITS (`LOCK_UNITS)
  ) u_store (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .set_all_i (do_all_lock || any_reset),
    .clr_all_i (do_all_unlock),
    .wr_en_i   (do_lock || do_unlock),
    .wr_idx_i  (flash_lock_pkg::unit_of(cmd_r.addr[`ADDR_W-1:0])),
    .wr_val_i  (do_lock),
    .chk_idx_i (flash_lock_pkg::unit_of(pe_req_i.addr)),
    .chk_o     (chk_bit),
    .rd_clk_i  (sck_i),
    .rd_en_i   (rd_en),
    .rd_idx_i  (rd_idx),
    .rd_o      (lk_rd)
  );

  // lock bit only counts in lock scheme; else the range outcome
  assign locked = lock_scheme_select_i ? chk_bit
                                       : range_protect_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pe_pend_r   <= 1'b0;
      pe_go_o     <= 1'b0;
      pe_refuse_o <= 1'b0;
    end else begin
      pe_pend_r   <= pe_req_i.valid && !any_reset;
      pe_go_o     <= pe_pend_r && !locked && !any_reset;
      pe_refuse_o <= pe_pend_r && locked && !any_reset;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pe_abort_o         <= 1'b0;
      soft_reset_o       <= 1'b0;
      write_latch_flag_o <= 1'b0;
    end else begin
      pe_abort_o         <= fire || !pin_s2_r;
      soft_reset_o       <= fire;
      write_latch_flag_o <= latch_r;
    end
  end

endmodule

// ==== flash_lock_sva.sv ====
/*
 Port checker for flash_lock_ctrl, bound to every instance.
 Assumes clk_i is the core clock and rst_b_i its reset.
*/
`timescale 1ns/1ps
module flash_lock_sva (
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire logic                    cs_b_i,
  input wire logic                    reset_pin_b_i,
  input wire logic [3:0]              io_oe_b_o,
  input wire logic                    lock_scheme_select_i,
  input wire logic                    range_protect_i,
  input wire flash_lock_pkg::pe_req_t pe_req_i,
  input wire logic                    pe_go_o,
  input wire logic                    pe_refuse_o,
  input wire logic                    pe_abort_o,
  input wire logic                    write_latch_flag_o,
  input wire logic                    soft_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  pe_answer_a: assert property (
    pe_req_i.valid |-> ##2 (pe_go_o ^ pe_refuse_o))
    else $error("request without exactly one answer");
  pe_unasked_a: assert property (!$past(pe_req_i.valid, 2) |->
    !pe_go_o && !pe_refuse_o) else $error("answer without request");
  range_used_a: assert property (
    pe_req_i.valid && !lock_scheme_select_i |->
    ##2 pe_refuse_o == $past(range_protect_i, 2))
    else $error("range outcome ignored");
  srst_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset longer than one cycle");
  srst_abort_a: assert property (soft_reset_o |-> pe_abort_o)
    else $error("soft reset without abort");
  srst_latch_a: assert property (
    soft_reset_o |-> ##[0:2] !write_latch_flag_o)
    else $error("latch kept over soft reset");
  pin_float_a: assert property (!reset_pin_b_i |-> io_oe_b_o == 4'hF)
    else $error("lanes driven while reset pin low");
  pin_abort_a: assert property (
    $fell(reset_pin_b_i) |-> ##[1:5] pe_abort_o)
    else $error("reset pin did not abort");
  idle_float_a: assert property (cs_b_i && $past(cs_b_i) |->
    io_oe_b_o == 4'hF) else $error("lanes driven while deselected");
  cover property (pe_refuse_o);
  cover property (soft_reset_o);
  cover property (io_oe_b_o == 4'h0);
endmodule

bind flash_lock_ctrl flash_lock_sva sva_i (.clk_i, .rst_b_i, .cs_b_i,
  .reset_pin_b_i, .io_oe_b_o, .lock_scheme_select_i, .range_protect_i,
  .pe_req_i, .pe_go_o, .pe_refuse_o, .pe_abort_o, .write_latch_flag_o,
  .soft_reset_o);

// ==== flash_host_model.sv ====
/*
 Host controller model: select, mode 0 serial clock and lanes.
 Assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/1ps
module flash_host_model (
  input  wire logic       quad_i,
  input  wire logic [3:0] pad_i,
  output logic            sck_o,
  output logic            cs_b_o,
  output logic [3:0]      io_o
);
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    io_o = 4'h5;
  end
  // clock runs only inside a frame; unused lanes keep toggling
  task automatic xfer(input logic [63:0] tx, input int nb, input int rb,
                      output logic [127:0] rx);
    int w;
    w = quad_i ? 4 : 1;
    rx = '0;
    cs_b_o = 1'b0;
    for (int i = 0; i < nb; i += w) begin
      io_o = quad_i ? tx[63-i -: 4] : {~io_o[3:1], tx[63-i]};
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
    end
    for (int i = 0; i < rb; i += w) begin
      io_o = ~io_o;
      #15 sck_o = 1'b1;
      rx = quad_i ? {rx[123:0], pad_i} : {rx[126:0], pad_i[1]};
      #15 sck_o = 1'b0;
    end
    #15 cs_b_o = 1'b1;
    io_o = ~io_o;
    #45;
  endtask
endmodule

// ==== flash_block_lock_and_reset_tb_top.sv ====
/*
 Self-checking bench of flash_lock_ctrl with the host model on the link.
 Assumes flash_lock_defs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "flash_lock_defs.svh"
module flash_block_lock_and_reset_tb_top;
  // arbitrary identifier value
  localparam logic [127:0] UID = 128'hA5A50F0F12345678_9ABCDEF0C3C37E81;
  logic                    clk_i = 1'b0;
  logic                    rst_b_i = 1'b0;
  logic                    pin_b = 1'b1;
  logic                    sel = 1'b1;
  logic                    rng = 1'b0;
  logic                    quad = 1'b0;
  flash_lock_pkg::pe_req_t pe_req = '0;
  logic                    sck, cs_b, go, refuse, abort, write_latch_flag, srst;
  logic [3:0]              h_io, d_io, d_oe_b, pad;
  logic [15:0]             lfsr = 16'h0038;
  logic [127:0]            rx;
  logic [21:0]             a;
  logic                    exp_lock [`LOCK_UNITS];
  logic [21:0]             corner [6] = '{22'h000000, 22'h00F000,
    22'h3F0000, 22'h3FFFFF, 22'h010000, 22'h3EFFFF};
  int                      errors = 0;
  int                      comparisons = 0;
  logic                    srst_seen = 1'b0;
  logic                    abort_seen = 1'b0;

  assign pad = (d_oe_b & h_io) | (~d_oe_b & d_io);
  always #2.5 clk_i = ~clk_i;
  // one-cycle pulses are caught here and checked after the frame
  always @(posedge clk_i) begin
    if (srst) srst_seen <= 1'b1;
    if (abort) abort_seen <= 1'b1;
  end

  flash_lock_ctrl #(.UNIQUE_ID(UID), .PULSE_CYC(4)) uut (.clk_i, .rst_b_i,
    .sck_i(sck), .cs_b_i(cs_b), .reset_pin_b_i(pin_b), .io_i(pad),
    .io_o(d_io), .io_oe_b_o(d_oe_b), .quad_command_mode_i(quad),
    .lock_scheme_select_i(sel), .range_protect_i(rng), .pe_req_i(pe_req),
    .pe_go_o(go), .pe_refuse_o(refuse), .pe_abort_o(abort),
    .write_latch_flag_o(write_latch_flag), .soft_reset_o(srst));
  flash_host_model host (.quad_i(quad), .pad_i(pad), .sck_o(sck),
    .cs_b_o(cs_b), .io_o(h_io));

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int unit_idx(input logic [21:0] x);
    if (x[21:16] == 6'h00) return x[15:12];
    if (x[21:16] == 6'h3F) return 16 + x[15:12];
    return 31 + x[21:16];
  endfunction

  task automatic check(input logic [127:0] got, input logic [127:0] exp,
                       input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic set_all(input logic v);
    for (int i = 0; i < `LOCK_UNITS; i++) exp_lock[i] = v;
  endtask
  // commands run a few core cycles after select rises
  task automatic frame(input logic [7:0] op, input logic [21:0] x,
                       input int nb, input int rb);
    // offset keeps serial edges off the core clock edges
    #1 host.xfer({op, 2'b00, x, 32'h0}, nb, rb, rx);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic locked_op(input logic [7:0] op, input logic [21:0] x,
                           input int nb);
    frame(`OP_LATCH_SET, 22'h0, 8, 0);
    check(write_latch_flag, 1'b1, "latch not set");
    frame(op, x, nb, 0);
  endtask
  task automatic query(input logic [21:0] x);
    frame(`OP_LOCK_QUERY, x, 32, 8);
    check(rx[7:0], {7'h0, exp_lock[unit_idx(x)]}, "lock status");
  endtask
  task automatic pe_try(input logic [21:0] x);
    @(posedge clk_i);
    pe_req <= '{valid: 1'b1, addr: x};
    sel <= lfsr[0];
    rng <= lfsr[1];
    @(posedge clk_i);
    pe_req.valid <= 1'b0;
    @(posedge clk_i);
    #1 check({go, refuse}, (sel ? exp_lock[unit_idx(x)] : rng) ? 2'b01 : 2'b10,
             "pe answer");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    report_and_stop();
  end

  initial begin
    set_all(1'b1);
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int k = 0; k < 6; k++) query(corner[k]);
    frame(`OP_LATCH_SET, 22'h0, 8, 0);
    frame(`OP_LATCH_CLR, 22'h0, 8, 0);
    check(write_latch_flag, 1'b0, "latch not cleared");
    frame(`OP_SINGLE_UNLOCK, corner[0], 32, 0);
    query(corner[0]);
    for (int k = 0; k < 8; k++) begin
      lfsr = next_rand(lfsr);
      a = (k < 4) ? corner[k] : {lfsr[15:10], lfsr};
      locked_op(`OP_SINGLE_UNLOCK, a, 32);
      exp_lock[unit_idx(a)] = 1'b0;
      check(write_latch_flag, 1'b0, "latch kept");
      query(a);
      query(a ^ 22'h001000);
    end
    locked_op(`OP_SINGLE_LOCK, corner[0], 36);
    query(corner[0]);
    locked_op(`OP_SINGLE_LOCK, corner[0], 32);
    exp_lock[unit_idx(corner[0])] = 1'b1;
    query(corner[0]);
    for (int k = 0; k < 16; k++) begin
      lfsr = next_rand(lfsr);
      pe_try(k < 6 ? corner[k] : {lfsr[15:10], lfsr});
    end
    quad <= 1'b1;
    frame(8'h00, 22'h0, 8, 0);
    locked_op(`OP_ALL_UNLOCK, 22'h0, 8);
    set_all(1'b0);
    for (int k = 0; k < 6; k++) query(corner[k]);
    quad <= 1'b0;
    frame(8'h00, 22'h0, 8, 0);
    locked_op(`OP_ALL_LOCK, 22'h0, 8);
    set_all(1'b1);
    query(corner[3]);
    locked_op(`OP_SINGLE_UNLOCK, corner[1], 32);
    exp_lock[unit_idx(corner[1])] = 1'b0;
    frame(`OP_RESET_ARM, 22'h0, 8, 0);
    frame(`OP_LATCH_SET, 22'h0, 8, 0);
    frame(`OP_RESET_FIRE, 22'h0, 8, 0);
    check({srst_seen, abort_seen}, 2'b00, "reset without arm");
    query(corner[1]);
    frame(`OP_LATCH_SET, 22'h0, 8, 0);
    frame(`OP_RESET_ARM, 22'h0, 8, 0);
    frame(`OP_RESET_FIRE, 22'h0, 8, 0);
    check({srst_seen, abort_seen}, 2'b11, "no reset pulse");
    set_all(1'b1);
    check(write_latch_flag, 1'b0, "latch after soft reset");
    query(corner[1]);
    locked_op(`OP_SINGLE_UNLOCK, corner[2], 32);
    exp_lock[unit_idx(corner[2])] = 1'b0;
    pin_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    pin_b <= 1'b1;
    repeat (20) @(posedge clk_i);
    query(corner[2]);
    frame(`OP_LATCH_SET, 22'h0, 8, 0);
    pin_b <= 1'b0;
    repeat (20) @(posedge clk_i);
    check(d_oe_b, 4'hF, "lanes driven in pin reset");
    pin_b <= 1'b1;
    repeat (6000) @(posedge clk_i);
    set_all(1'b1);
    check(write_latch_flag, 1'b0, "latch after pin reset");
    query(corner[2]);
    frame(`OP_UID_DEFAULT, 22'h0, 40, 128);
    check(rx, UID, "unique id");
    report_and_stop();
  end
endmodule
